/* File: hw/ncs_host_ctl.sv */
// ncs_host_ctl: apb-driven controller that issues command, address and
// data cycles to a nand die, polls ready/busy and guards command order.
// assumes the die's io and ready/busy pins are synchronous to pclk and the
// bench resolves the shared io wire from io_oe.
// How it works
// RULE1: current page result read on status bit 0
// RULE2: previous page result on status bit 1
// RULE3: bit 0 trusted only when array ready
// RULE4: bit 1 trusted only when cache ready
// RULE5: first two-plane page must select plane 0
// RULE6: after dummy confirm, 81h selects plane 1
// RULE7: 15h starts pair; sequence ends with 10h
// RULE8: 70h, 78h, 75h read status after confirm
// RULE9: between 11h and 81h only status/reset
// RULE10: both planes share page bits except plane
// RULE11: 35h loads whole source page for readback
// RULE12: copy-back starts 85h, programs after 10h
// RULE13: 85h random input edits buffered copy data
// RULE14: 70h allowed once programming has started
// RULE15: status keeps coming until next command
// RULE16: two-plane copy-back programs both pages together
// RULE17: erase takes two block address cycles
// RULE18: erase begins at d0h confirm strobe edge
// RULE19: during erase only status and reset
// RULE20: erase done on pin; bit 0 result
// RULE21: status reads accepted during dummy busy
// RULE22: ffh aborts, clears, pulls pin busy
// RULE23: die drives io only when chip and read low
// RULE24: wait for ready before other commands
// RULE25: bound the ready wait, report expiry
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
module ncs_host_ctl
  import ncs_pkg::*;
#(
  parameter int TMO_RESET = TMO_CYC, // default ready wait limit
  parameter int DIV       = STROBE_DIV // pclk cycles per strobe phase
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output ncs_pins_t              nand_o,
  input  wire logic [7:0]        nand_io_i,
  input  wire logic              nand_rb_n
);

  // whole controller state in one record
  typedef struct packed {
    ncs_st_t    st;        // bus cycle sequencer
    ncs_kind_t  kind;      // kind of cycle in flight
    logic [7:0] val;       // byte of cycle in flight
    ncs_pins_t  pins;      // registered pin drive
    logic [7:0] rdata;     // last byte read from the die
    logic       order_err; // sticky: refused out-of-order cycle
    logic       plane_err; // sticky: refused bad plane/page address
    logic       tmo_err;   // sticky: ready wait expired
    logic       in_dummy;  // between dummy confirm and 81h
    logic [1:0] seq;       // 0 none, 1 after 80h, 2 after 81h
    logic [2:0] adr_idx;   // address cycles sent since 80h/81h
    logic [7:0] page;      // page byte of the first plane
    logic [31:0] cnt;      // settle and wait counter
    logic [31:0] tmo_lim;  // ready wait limit in pclk cycles
  } ncs_ctl_t;

  ncs_ctl_t   s_q, s_d;
  logic       tick;      // strobe phase boundary
  logic       wr;        // apb write access phase
  logic       go;        // command register write while idle
  logic       ord_bad;   // request breaks command order
  logic       plane_bad; // request breaks plane addressing
  ncs_kind_t  rq_kind;   // requested cycle kind
  logic [7:0] rq_val;    // requested byte

  ncs_strobe_div #(.DIV(DIV)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (s_q.st == ST_SETUP || s_q.st == ST_HOLD),
    .tick    (tick)
  );

  assign rq_kind = ncs_kind_t'(pwdata[CMD_KIND_LSB +: 3]);
  assign rq_val  = pwdata[CMD_VAL_LSB +: 8];
  assign wr      = psel && penable && pwrite;
  assign go      = wr && paddr == REG_CMD && s_q.st == ST_IDLE;
  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign nand_o  = s_q.pins;

  // order guard, judged against the pin and sequence state at request time
  always_comb begin
    ord_bad = 1'b0;
    case (rq_kind)
      K_CMD: begin
        if (!nand_rb_n && !is_stat_rst(rq_val)) begin
          ord_bad = 1'b1; // [RULE24] [RULE19]
        end else if (s_q.in_dummy && !is_stat_rst(rq_val) &&
                     rq_val != OP_PLANE2_IN) begin
          ord_bad = 1'b1; // [RULE9]
        end else if (rq_val == OP_PLANE2_IN && !s_q.in_dummy) begin
          ord_bad = 1'b1; // [RULE6]
        end
      end
      K_ADDR, K_WDATA: ord_bad = !nand_rb_n; // [RULE24]
      K_RDATA, K_WAIT: ord_bad = 1'b0; // status polls stay legal
      default: ord_bad = 1'b1; // unknown kind is never sent
    endcase
  end

  // plane guard on the plane and page address cycles
  always_comb begin
    plane_bad = 1'b0;
    if (rq_kind == K_ADDR) begin
      if (s_q.seq == 2'd1 && s_q.adr_idx == ADDR_PLANE_IDX &&
          rq_val[ADDR_PLANE_BIT]) begin
        plane_bad = 1'b1; // [RULE5]
      end
      if (s_q.seq == 2'd2 && s_q.adr_idx == ADDR_PLANE_IDX &&
          !rq_val[ADDR_PLANE_BIT]) begin
        plane_bad = 1'b1; // [RULE6]
      end
      if (s_q.seq == 2'd2 && s_q.adr_idx == ADDR_PAGE_IDX &&
          rq_val != s_q.page) begin
        plane_bad = 1'b1; // [RULE10]
      end
    end
  end

  // next state: register writes, sequencer, flags (set beats clear)
  always_comb begin
    s_d = s_q;
    // write-one-to-clear first, so a set below in the same cycle wins
    if (wr && paddr == REG_STAT) begin
      if (pwdata[ST_ORDER_ERR]) s_d.order_err = 1'b0;
      if (pwdata[ST_PLANE_ERR]) s_d.plane_err = 1'b0;
      if (pwdata[ST_TMO_ERR])   s_d.tmo_err   = 1'b0;
    end
    if (wr && paddr == REG_TMO) begin
      s_d.tmo_lim = pwdata;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (go && ord_bad) begin
          s_d.order_err = 1'b1;
        end else if (go && plane_bad) begin
          s_d.plane_err = 1'b1;
        end else if (go) begin
          s_d.kind = rq_kind;
          s_d.val  = rq_val;
          s_d.cnt  = '0;
          if (rq_kind == K_WAIT) begin
            s_d.st = ST_WAITWB;
          end else begin
            s_d.st                 = ST_SETUP;
            s_d.pins.ce_n          = 1'b0;
            s_d.pins.cle           = rq_kind == K_CMD;
            s_d.pins.ale           = rq_kind == K_ADDR;
            s_d.pins.io_o          = rq_val;
            // die owns io while it drives a read cycle [RULE23]
            s_d.pins.io_oe         = rq_kind != K_RDATA;
            s_d.pins.we_n          = rq_kind == K_RDATA;
            s_d.pins.read_strobe_n = rq_kind != K_RDATA;
          end
          if (rq_kind == K_CMD) begin
            case (rq_val)
              OP_SERIAL_IN: begin
                s_d.seq      = 2'd1;
                s_d.adr_idx  = '0;
                s_d.in_dummy = 1'b0;
              end
              OP_PLANE2_IN: begin
                s_d.seq      = 2'd2;
                s_d.adr_idx  = '0;
                s_d.in_dummy = 1'b0; // [RULE6]
              end
              OP_DUMMY_CFM: s_d.in_dummy = 1'b1; // [RULE9]
              OP_PROG_CFM, OP_CACHE_CFM, OP_RESET: begin
                s_d.seq      = 2'd0; // [RULE7]
                s_d.in_dummy = 1'b0;
              end
              OP_READ_STATUS, OP_MP_STATUS_A, OP_MP_STATUS_B,
              OP_RAND_IN: s_d.seq = s_q.seq; // [RULE13]
              default: s_d.seq = 2'd0;
            endcase
          end
          if (rq_kind == K_ADDR && s_q.adr_idx < ADDR_CYCLES) begin
            s_d.adr_idx = s_q.adr_idx + 3'h1;
            if (s_q.seq == 2'd1 && s_q.adr_idx == ADDR_PAGE_IDX) begin
              s_d.page = rq_val; // kept to check the second plane
            end
          end
        end
      end
      ST_SETUP: begin
        if (tick) begin
          // rising strobe latches the byte; read samples before rising
          if (s_q.kind == K_RDATA) begin
            s_d.rdata              = nand_io_i; // [RULE1] [RULE2]
            s_d.pins.read_strobe_n = 1'b1;
          end else begin
            s_d.pins.we_n = 1'b1; // [RULE12]
          end
          s_d.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tick) begin
          s_d.pins = PINS_IDLE;
          s_d.st   = ST_IDLE;
        end
      end
      ST_WAITWB: begin
        // the pin may lag the confirm; do not trust it until settled
        s_d.cnt = s_q.cnt + 32'h1;
        if (s_q.cnt == 32'(WB_CYC - 1)) begin
          s_d.cnt = '0;
          s_d.st  = ST_POLL;
        end
      end
      ST_POLL: begin
        if (nand_rb_n) begin
          s_d.st = ST_IDLE; // [RULE3] [RULE4]
        end else if (s_q.cnt >= s_q.tmo_lim) begin
          s_d.tmo_err = 1'b1; // [RULE25]
          s_d.st      = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // register read mux and error answer
  always_comb begin
    prdata  = '0;
    pslverr = 1'b0;
    case (paddr)
      REG_CMD: begin
        prdata[CMD_VAL_LSB +: 8]  = s_q.val;
        prdata[CMD_KIND_LSB +: 3] = s_q.kind;
        // a request while a cycle is in flight is refused, not queued
        pslverr = psel && pwrite && s_q.st != ST_IDLE;
      end
      REG_STAT: begin
        prdata[ST_BUSY]      = s_q.st != ST_IDLE;
        prdata[ST_RB_RDY]    = nand_rb_n;
        prdata[ST_ORDER_ERR] = s_q.order_err;
        prdata[ST_PLANE_ERR] = s_q.plane_err;
        prdata[ST_TMO_ERR]   = s_q.tmo_err;
        prdata[ST_IN_DUMMY]  = s_q.in_dummy;
        prdata[ST_ARRAY_RDY] = s_q.rdata[SB_ARRAY_RDY];
        prdata[ST_CACHE_RDY] = s_q.rdata[SB_CACHE_RDY];
        // fail bits masked until their ready bit vouches for them
        prdata[ST_CUR_FAIL]  = s_q.rdata[SB_ARRAY_RDY] &&
                               s_q.rdata[SB_CUR_FAIL]; // [RULE3]
        prdata[ST_PREV_FAIL] = s_q.rdata[SB_CACHE_RDY] &&
                               s_q.rdata[SB_PREV_FAIL]; // [RULE4]
      end
      REG_RDATA: prdata[7:0] = s_q.rdata;
      REG_TMO:   prdata      = s_q.tmo_lim;
      default:   pslverr     = psel; // unmapped address
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.pins    <= PINS_IDLE;
      s_q.tmo_lim <= 32'(TMO_RESET);
    end else begin
      s_q <= s_d;
    end
  end

  a_busy_cmd_block: assert property (@(posedge pclk) disable iff (!presetn)
    go && rq_kind == K_CMD && !nand_rb_n && !is_stat_rst(rq_val)
    |=> s_q.st == ST_IDLE && s_q.order_err) // [RULE24]
    else $error("command sent while die busy");

  a_dummy_order: assert property (@(posedge pclk) disable iff (!presetn)
    go && s_q.in_dummy && rq_kind == K_CMD && nand_rb_n &&
    !is_stat_rst(rq_val) && rq_val != OP_PLANE2_IN
    |=> s_q.order_err && s_q.pins.we_n) // [RULE9]
    else $error("illegal command between dummy confirm and 81h");

  a_plane_first: assert property (@(posedge pclk) disable iff (!presetn)
    go && rq_kind == K_ADDR && s_q.seq == 2'd1 && nand_rb_n &&
    s_q.adr_idx == ADDR_PLANE_IDX && rq_val[ADDR_PLANE_BIT]
    |=> s_q.plane_err && !s_q.pins.ale) // [RULE5]
    else $error("first page sent to plane 1");

  a_plane_second: assert property (@(posedge pclk) disable iff (!presetn)
    go && rq_kind == K_ADDR && s_q.seq == 2'd2 && nand_rb_n &&
    s_q.adr_idx == ADDR_PLANE_IDX && !rq_val[ADDR_PLANE_BIT]
    |=> s_q.plane_err && s_q.st == ST_IDLE) // [RULE6]
    else $error("second page sent to plane 0");

  a_page_match: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.pins.ale && s_q.seq == 2'd2 && s_q.adr_idx == ADDR_PLANE_IDX &&
    s_q.st == ST_SETUP |-> s_q.val == s_q.page) // [RULE10]
    else $error("plane pages differ in page bits");

  a_read_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.pins.read_strobe_n |-> !s_q.pins.ce_n && !s_q.pins.io_oe)
    // [RULE23]
    else $error("io driven during read cycle");

  a_tmo_bound: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == ST_POLL && !nand_rb_n && s_q.cnt >= s_q.tmo_lim
    |=> s_q.tmo_err && s_q.st == ST_IDLE) // [RULE25]
    else $error("ready wait not ended at limit");

  a_rb_ready_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == ST_POLL && nand_rb_n
    |=> s_q.st == ST_IDLE && !$rose(s_q.tmo_err)) // [RULE3]
    else $error("ready not honoured");

  a_we_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_q.pins.we_n) |-> !s_q.pins.ce_n && s_q.pins.io_oe &&
    $stable(s_q.pins.io_o) && $stable(s_q.pins.cle)) // [RULE12]
    else $error("byte not held across strobe rise");

endmodule

/* File: hw/ncs_pkg.sv */
// ncs_pkg: constants, opcodes, register map and state types for the
// host-side controller of a multi-level-cell nand flash die.
// assumes a 250 mhz pclk and a die driven over its own 8-bit bus pins.
package ncs_pkg;

  // opcodes the controller recognises while guarding command order
  localparam logic [7:0] OP_READ_STATUS = 8'h70; // plain status read
  localparam logic [7:0] OP_MP_STATUS_A = 8'h78; // per-plane status read
  localparam logic [7:0] OP_MP_STATUS_B = 8'h75; // alternate status read
  localparam logic [7:0] OP_RESET       = 8'hff; // abort and clear
  localparam logic [7:0] OP_SERIAL_IN   = 8'h80; // first page data input
  localparam logic [7:0] OP_PLANE2_IN   = 8'h81; // second plane data input
  localparam logic [7:0] OP_DUMMY_CFM   = 8'h11; // dummy program confirm
  localparam logic [7:0] OP_PROG_CFM    = 8'h10; // program confirm
  localparam logic [7:0] OP_CACHE_CFM   = 8'h15; // cache program confirm
  localparam logic [7:0] OP_RAND_IN     = 8'h85; // copy-back / random input

  // status byte bit positions
  localparam int SB_CUR_FAIL  = 0; // current page fail
  localparam int SB_PREV_FAIL = 1; // previous page fail
  localparam int SB_ARRAY_RDY = 5; // array ready
  localparam int SB_CACHE_RDY = 6; // cache ready

  // five address cycles: two column, then page byte, then plane byte
  localparam logic [2:0] ADDR_CYCLES    = 3'h5;
  localparam logic [2:0] ADDR_PAGE_IDX  = 3'h2; // carries page bits
  localparam logic [2:0] ADDR_PLANE_IDX = 3'h3; // low bit is plane select
  localparam int         ADDR_PLANE_BIT = 0;

  // apb register map, byte addresses
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] REG_CMD   = 8'h00; // issue one bus cycle
  localparam logic [7:0] REG_STAT  = 8'h04; // flags and status view
  localparam logic [7:0] REG_RDATA = 8'h08; // last byte read
  localparam logic [7:0] REG_TMO   = 8'h0c; // ready wait limit, cycles

  // command register fields
  localparam int CMD_VAL_LSB  = 0;
  localparam int CMD_KIND_LSB = 8;

  // status register bit positions
  localparam int ST_BUSY       = 0;
  localparam int ST_RB_RDY     = 1;
  localparam int ST_ORDER_ERR  = 2;
  localparam int ST_PLANE_ERR  = 3;
  localparam int ST_TMO_ERR    = 4;
  localparam int ST_IN_DUMMY   = 5;
  localparam int ST_ARRAY_RDY  = 6;
  localparam int ST_CACHE_RDY  = 7;
  localparam int ST_CUR_FAIL   = 8;
  localparam int ST_PREV_FAIL  = 9;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_WB_NS       = 100; // confirm to busy settle, least
  localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_TMO_US      = 5000; // default ready wait limit
  localparam int TMO_CYC = (T_TMO_US * 1000) / CLK_PERIOD_NS;
  localparam int STROBE_DIV    = 5;   // pclk cycles per strobe phase

  // kinds of bus cycle that software may request
  typedef enum logic [2:0] {
    K_CMD   = 3'b000,
    K_ADDR  = 3'b001,
    K_WDATA = 3'b010,
    K_RDATA = 3'b011,
    K_WAIT  = 3'b100
  } ncs_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_HOLD   = 3'b010,
    ST_WAITWB = 3'b011,
    ST_POLL   = 3'b100
  } ncs_st_t;

  // pins toward the die
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic [7:0] io_o;
    logic       io_oe;
  } ncs_pins_t;

  localparam ncs_pins_t PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
    we_n: 1'b1, read_strobe_n: 1'b1, io_o: 8'h00, io_oe: 1'b0};

  // status reads and reset are legal whatever the die is doing
  function automatic logic is_stat_rst(input logic [7:0] op);
    return op == OP_READ_STATUS || op == OP_MP_STATUS_A ||
           op == OP_MP_STATUS_B || op == OP_RESET;
  endfunction

endpackage

/* File: hw/ncs_strobe_div.sv */
// ncs_strobe_div: one-cycle tick every DIV pclk cycles while run is high.
// assumes run rises at the start of a bus cycle; the count restarts when
// run is low so every phase lasts a full DIV cycles.
`timescale 1ns/10ps
module ncs_strobe_div
  import ncs_pkg::*;
#(
  parameter int DIV = STROBE_DIV
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      tick
);

  typedef struct packed {
    logic [7:0] cnt; // cycles since last tick
  } ncs_div_t;

  localparam logic [7:0] LAST = 8'(DIV - 1);

  ncs_div_t s_q, s_d;

  // count up while running, wrap on the tick
  always_comb begin
    s_d = s_q;
    if (!run || s_q.cnt == LAST) begin
      s_d.cnt = 8'h00;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  assign tick = run && s_q.cnt == LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* File: sim/ncs_die_model.sv */
// ncs_die_model: behavioural nand die seen from the controller's pins.
// assumes pins are flop outputs on pclk; the bench resolves the io wire
// and the pulled-up ready/busy wire from io_d and rb_n.
`timescale 1ns/10ps
module ncs_die_model
  import ncs_pkg::*;
#(
  parameter int T_PROG = 300, // busy after program or erase confirm
  parameter int T_DBSY = 40,  // short busy after the dummy confirm
  parameter int T_RST  = 40   // busy after reset
) (
  input  wire logic       pclk,
  input  wire ncs_pins_t  pins,
  input  wire logic       fail_cur,
  input  wire logic       fail_prev,
  output logic [7:0]      io_d,
  output logic            rb_n,
  output logic [7:0]      last_cmd
);
  logic       we_q = 1'b1;    // write strobe one cycle ago
  int         cnt = 0;        // busy cycles left
  logic       stat_mode = 0;  // read cycles return status
  logic [7:0] held = 8'h00;   // last byte driven
  logic [7:0] sbyte;          // status byte
  logic       drv;            // die owns the io wire

  // drive only while both selects are low; else show a changed value
  // so a stale byte can never pass for fresh data
  assign drv = !pins.ce_n && !pins.read_strobe_n;
  // array and cache ready share one counter in this model
  assign sbyte = {1'b1, cnt == 0, cnt == 0, 3'b000, fail_prev,
                  fail_cur};
  assign io_d = drv ? (stat_mode ? sbyte : 8'h3c) : ~held;
  assign rb_n = (cnt == 0);

  // latch commands on the rising write strobe
  always @(posedge pclk) begin
    we_q <= pins.we_n;
    if (drv) begin
      held <= io_d;
    end
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    if (!we_q && pins.we_n && !pins.ce_n && pins.cle) begin
      last_cmd  <= pins.io_o;
      // status mode lasts until the next command
      stat_mode <= is_stat_rst(pins.io_o) && pins.io_o != OP_RESET;
      case (pins.io_o)
        8'h10, 8'h15, 8'h35, 8'hd0: begin
          cnt <= T_PROG;
        end
        8'h11: begin
          cnt <= T_DBSY;
        end
        8'hff: begin
          cnt <= T_RST;
        end
        // setup commands only steer buffers
        default: ; // status reads leave busy alone
      endcase
    end
  end
endmodule

/* File: sim/ncs_host_ctl_tb.sv */
// ncs_host_ctl_tb: apb-driven tests of the controller against a die model.
// assumes a short timeout and DIV=2 so each nand bus cycle is 4 pclks.
`timescale 1ns/10ps
module ncs_host_ctl_tb
  import ncs_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ncs_pins_t   nand_o;
  logic [7:0]  die_io;      // byte the die offers
  logic [7:0]  io_w;        // resolved io wire
  logic        rb_n;        // resolved ready/busy wire
  logic        fail_cur = 1'b0;
  logic        fail_prev = 1'b0;
  logic [7:0]  last_cmd;    // last command the die latched
  logic [31:0] rv;          // data of the last apb transfer
  logic        err;         // error of the last apb transfer
  int          n_mismatch = 0;
  int          checks = 0;
  logic [7:0]  ops [3] = '{OP_READ_STATUS, OP_MP_STATUS_A, OP_MP_STATUS_B};

  always #2 pclk = ~pclk;
  // host wins the io wire only while it enables its driver
  assign io_w = nand_o.io_oe ? nand_o.io_o : die_io;

  ncs_host_ctl #(.TMO_RESET(200), .DIV(2)) u_ncs_host_ctl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nand_o(nand_o),
    .nand_io_i(io_w), .nand_rb_n(rb_n));

  ncs_die_model u_ncs_die_model (
    .pclk(pclk), .pins(nand_o), .fail_cur(fail_cur),
    .fail_prev(fail_prev), .io_d(die_io), .rb_n(rb_n),
    .last_cmd(last_cmd));

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      n_mismatch++;
      $display("FAIL pready expected 1 seen %b", pready);
      test_done();
    end
  endtask

  // poll the busy flag with a bound; a hang is a mismatch
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rv[ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      n_mismatch++;
      $display("FAIL busy expected 0 seen %b", rv[ST_BUSY]);
      test_done();
    end
  endtask

  task automatic bus(input ncs_kind_t k, input logic [7:0] b);
    apb(1'b1, REG_CMD, {21'h0, k, b});
    idle();
  endtask

  // five address cycles; page byte third, plane select fourth
  task automatic addr5(input logic [7:0] pg, input logic pl);
    for (int i = 0; i < 5; i++) begin
      bus(K_ADDR, i == 2 ? pg : (i == 3 ? {7'h0, pl} : 8'h00));
    end
  endtask

  task automatic sbit(input string nm, input int i, input logic e);
    apb(1'b0, REG_STAT, 32'h0);
    chk(nm, {31'h0, e}, {31'h0, rv[i]});
  endtask

  // hang guard for the whole run
  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    $display("FAIL run expected end seen timeout");
    test_done();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and register access
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat reset", 32'h2, rv);
    apb(1'b0, REG_TMO, 32'h0);
    chk("tmo reset", 32'd200, rv);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rv);
    apb(1'b1, REG_TMO, 32'd1000);
    apb(1'b0, REG_TMO, 32'h0);
    chk("tmo rw", 32'd1000, rv);
    $display("test registers done");
    // two-plane cache program with status reads
    fail_prev <= 1'b1;
    bus(K_CMD, OP_SERIAL_IN);
    addr5(8'h07, 1'b0);
    bus(K_WDATA, 8'ha5);
    bus(K_CMD, OP_DUMMY_CFM);
    chk("dummy cmd", 32'h11, {24'h0, last_cmd});
    sbit("in dummy", ST_IN_DUMMY, 1'b1);
    bus(K_CMD, OP_READ_STATUS);
    bus(K_RDATA, 8'h00);
    sbit("dummy busy", ST_CACHE_RDY, 1'b0);
    bus(K_WAIT, 8'h00);
    bus(K_CMD, OP_PROG_CFM);
    sbit("dummy order", ST_ORDER_ERR, 1'b1);
    apb(1'b1, REG_STAT, 32'h4);
    bus(K_CMD, OP_PLANE2_IN);
    // plane byte 0 after 81h is refused twice, then the right bytes go
    addr5(8'h07, 1'b0);
    sbit("plane1 err", ST_PLANE_ERR, 1'b1);
    apb(1'b1, REG_STAT, 32'h8);
    bus(K_ADDR, 8'h01);
    bus(K_ADDR, 8'h00);
    bus(K_WDATA, 8'h5a);
    bus(K_CMD, OP_CACHE_CFM);
    bus(K_WAIT, 8'h00);
    sbit("plane ok", ST_PLANE_ERR, 1'b0);
    for (int j = 0; j < 3; j++) begin
      bus(K_CMD, ops[j]);
      bus(K_RDATA, 8'h00);
      bus(K_RDATA, 8'h00);
      apb(1'b0, REG_RDATA, 32'h0);
      chk("status byte", 32'he2, rv);
    end
    apb(1'b0, REG_STAT, 32'h0);
    chk("prev cur fail", 32'h2, {30'h0, rv[9:8]});
    $display("test cache program done");
    // order and plane refusals
    bus(K_CMD, OP_PLANE2_IN);
    sbit("order err", ST_ORDER_ERR, 1'b1);
    chk("no pin cycle", 32'h75, {24'h0, last_cmd});
    apb(1'b1, REG_STAT, 32'h4);
    sbit("order clear", ST_ORDER_ERR, 1'b0);
    bus(K_CMD, OP_SERIAL_IN);
    addr5(8'h07, 1'b1);
    sbit("plane err", ST_PLANE_ERR, 1'b1);
    apb(1'b1, REG_STAT, 32'h8);
    bus(K_CMD, OP_RESET);
    bus(K_WAIT, 8'h00);
    $display("test refusals done");
    // erase with busy guard and result
    fail_cur <= 1'b1;
    fail_prev <= 1'b0;
    bus(K_CMD, 8'h60);
    bus(K_ADDR, 8'h00);
    bus(K_ADDR, 8'h01);
    apb(1'b1, REG_CMD, {21'h0, K_CMD, 8'hd0});
    apb(1'b1, REG_CMD, {21'h0, K_CMD, OP_READ_STATUS});
    chk("cmd while busy", 32'h1, {31'h0, err});
    idle();
    bus(K_CMD, OP_SERIAL_IN);
    sbit("busy refuse", ST_ORDER_ERR, 1'b1);
    apb(1'b1, REG_STAT, 32'h4);
    bus(K_CMD, OP_READ_STATUS);
    bus(K_RDATA, 8'h00);
    sbit("erase busy", ST_CACHE_RDY, 1'b0);
    bus(K_WAIT, 8'h00);
    bus(K_RDATA, 8'h00);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("erase status", 32'he1, rv);
    sbit("erase fail", ST_CUR_FAIL, 1'b1);
    $display("test erase done");
    // ready wait limit, then reset out of busy
    apb(1'b1, REG_TMO, 32'd20);
    bus(K_CMD, 8'h60);
    bus(K_ADDR, 8'h00);
    bus(K_ADDR, 8'h01);
    bus(K_CMD, 8'hd0);
    bus(K_WAIT, 8'h00);
    sbit("timeout", ST_TMO_ERR, 1'b1);
    bus(K_CMD, OP_RESET);
    sbit("reset busy", ST_RB_RDY, 1'b0);
    apb(1'b1, REG_TMO, 32'd1000);
    bus(K_WAIT, 8'h00);
    sbit("reset ready", ST_RB_RDY, 1'b1);
    $display("test timeout done");
    test_done();
  end
endmodule
